// ---- dv/mcg_rx_model.sv ----
module mcg_rx_model (
    // line from the transmitter
    input  wire logic        clk,
    input  wire logic        pin,
    input  wire logic        start,
    input  wire logic [31:0] half,
    // captured half-bit levels
    output logic      [15:0] halves,
    output int               words
);
    initial words = 0;
    // sample mid half bit, far from any edge
    always begin
        @(negedge clk iff start);
        for (int i = 0; i < 16; i++) begin
            repeat (i == 0 ? half / 2 : half) @(negedge clk);
            halves = {halves[14:0], pin};
        end
        words = words + 1;
    end
endmodule

// ---- dv/mcg_tx_bench.sv ----
module mcg_tx_bench import mcg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK = 1'b0;
    logic        RST = 1'b1;
    logic [15:0] ADDR = 16'h0000;
    logic [7:0]  WDATA = 8'h00;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic [7:0]  RDATA;
    logic        pin;
    logic        irq;
    logic [15:0] halves;
    int          half = 4;
    int          words;
    int          n_fail = 0;
    int          n_tests = 0;
    int          cyc = 0;

    mcg_tx mcg_tx_inst (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .ENCODED_OUTPUT_PIN(pin), .TRANSMIT_START_INTERRUPT(irq));
    mcg_rx_model mcg_rx_model_inst (.clk(CLK), .pin(pin), .start(irq), .half(half),
        .halves(halves), .words(words));

    // clock and a watchdog so a hang still reaches the verdict
    always #2 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    // ------------------------------------------------
    // bus and check helpers
    // ------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk($sformatf("read %h", a), {8'h00, d}, {8'h00, e});
    endtask
    task automatic wait_words(input int n);
        for (int i = 0; i < 5000 && words < n; i++) @(posedge CLK);
    endtask
    task automatic wait_irq();
        for (int i = 0; i < 300 && irq !== 1'b1; i++) begin
            @(posedge CLK);
            #1;
        end
        chk("start pulse", {15'h0000, irq}, 16'h0001);
    endtask
    // expected line levels, two halves per bit, idle after the word
    function automatic logic [15:0] exp_h(input logic [7:0] c, input logic [2:0] n,
                                          input logic [7:0] d);
        logic [15:0] r;
        logic        b;
        for (int i = 0; i < 8; i++) begin
            if (i > int'(n)) r[15-2*i -: 2] = {2{c[POS_IDLE_LVL]}};
            else begin
                b = c[POS_BIT_ORDER] ? d[i] : d[int'(n) - i];
                r[15-2*i -: 2] = {c[POS_LINE_CODE] ? b : ~b, b};
            end
        end
        return r;
    endfunction
    task automatic cfg(input logic [7:0] c, input logic [2:0] n, input logic [4:0] k,
                       input logic [2:0] s);
        wr(ADDR_CONTROL, 8'h00); // stop before reconfiguring
        wr(ADDR_BASE_CLK, {5'h00, s});
        wr(ADDR_BAUD_DIV, {3'h0, k});
        wr(ADDR_BIT_COUNT, {5'h00, n});
        wr(ADDR_CONTROL, c); // enable and fields in one write
        half = (k < 5'd4 ? 4 : int'(k)) << (s > 3'd5 ? 5 : int'(s));
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic reg_reset();
        rdchk(ADDR_CONTROL, RST_CONTROL);
        rdchk(ADDR_BASE_CLK, RST_BASE_CLK);
        rdchk(ADDR_BAUD_DIV, RST_BAUD_DIV);
        rdchk(ADDR_BIT_COUNT, RST_BIT_COUNT);
        rdchk(ADDR_STATUS, RST_STATUS);
        rdchk(16'hff40, 8'h00);
        wr(ADDR_STATUS, 8'hff);
        rdchk(ADDR_STATUS, 8'h00);
        wr(ADDR_BAUD_DIV, 8'hff);
        rdchk(ADDR_BAUD_DIV, 8'h1f);
        wr(ADDR_BASE_CLK, 8'hfd);
        rdchk(ADDR_BASE_CLK, 8'h05);
    endtask
    task automatic send(input logic [7:0] c, input logic [2:0] n, input logic [7:0] d,
                        input logic [4:0] k, input logic [2:0] s);
        int w;
        w = words;
        cfg(c, n, k, s);
        wr(ADDR_TX_BUFFER, d);
        wait_words(w + 1);
        chk("line", halves, exp_h(c, n, d));
        repeat (half) @(posedge CLK);
        rdchk(ADDR_STATUS, 8'h00);
    endtask
    // second byte queued mid word: busy never drops, next word follows
    task automatic back_to_back();
        int w;
        w = words;
        cfg(8'h90, 3'd7, 5'h04, 3'd0);
        wr(ADDR_TX_BUFFER, 8'h3c);
        wait_irq(); // count unchanged, so it is not written again
        wr(ADDR_TX_BUFFER, 8'hc6);
        for (int i = 0; i < 35; i++) rdchk(ADDR_STATUS, 8'h80);
        wait_words(w + 2);
        chk("second word", halves, exp_h(8'h90, 3'd7, 8'hc6));
        repeat (8) @(posedge CLK);
        rdchk(ADDR_STATUS, 8'h00);
    endtask
    task automatic abort_word();
        cfg(8'h80, 3'd7, 5'h1f, 3'd0);
        wr(ADDR_TX_BUFFER, 8'haa);
        wait_irq();
        rdchk(ADDR_STATUS, 8'h80);
        wr(ADDR_CONTROL, 8'h00);
        rdchk(ADDR_STATUS, 8'h00);
        wr(ADDR_TX_BUFFER, 8'h55);
        repeat (40) @(posedge CLK);
        rdchk(ADDR_STATUS, 8'h00);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        reg_reset();
        send(8'h80, 3'd7, 8'ha5, 5'h02, 3'd0);
        send(8'h93, 3'd2, 8'h5e, 5'h05, 3'd0);
        send(8'h81, 3'd4, 8'h3c, 5'h04, 3'd1);
        send(8'h92, 3'd0, 8'h01, 5'h04, 3'd6);
        back_to_back();
        abort_word();
        give_verdict();
    end
endmodule

bind mcg_tx mcg_tx_sva mcg_tx_sva_inst (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .ENCODED_OUTPUT_PIN(ENCODED_OUTPUT_PIN),
    .TRANSMIT_START_INTERRUPT(TRANSMIT_START_INTERRUPT));

// ---- dv/mcg_tx_sva.sv ----
module mcg_tx_sva
    import mcg_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // register port
    input  wire logic [15:0] ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    input  wire logic [7:0]  RDATA,
    // line
    input  wire logic        ENCODED_OUTPUT_PIN,
    input  wire logic        TRANSMIT_START_INTERRUPT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    logic [7:0] ctl;
    logic [7:0] next_ctl;
    logic       mapped;

    // shadow of the control register, kept from the bus alone
    always_comb begin
        next_ctl = ctl;
        if (WR && ADDR == ADDR_CONTROL) next_ctl = WDATA & MASK_CONTROL;
    end
    always_ff @(posedge CLK) begin
        ctl <= RST ? RST_CONTROL : next_ctl;
    end
    assign mapped = ADDR inside {ADDR_STATUS, ADDR_BIT_COUNT, ADDR_CONTROL,
                                 ADDR_BASE_CLK, ADDR_BAUD_DIV, ADDR_TX_BUFFER};

    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    rdata_quiet_a: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (RD && !mapped |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    status_bits_a: assert property (RD && ADDR == ADDR_STATUS |=> RDATA[6:0] == 7'h00)
        else $error("status unused bits set");
    control_read_a: assert property (RD && ADDR == ADDR_CONTROL |=> RDATA == ctl)
        else $error("control read differs from last write");
    base_mask_a: assert property (RD && ADDR == ADDR_BASE_CLK |=> RDATA[7:3] == 5'h00)
        else $error("base clock unused bits set");
    baud_mask_a: assert property (RD && ADDR == ADDR_BAUD_DIV |=> RDATA[7:5] == 3'h0)
        else $error("baud divisor unused bits set");
    start_spacing_a: assert property (TRANSMIT_START_INTERRUPT |=> !TRANSMIT_START_INTERRUPT [*7])
        else $error("start pulses closer than one bit");
    start_enabled_a: assert property (TRANSMIT_START_INTERRUPT |-> $past(ctl[POS_ENABLE]))
        else $error("word started while disabled");
    idle_level_a: assert property (!ctl[POS_ENABLE] && $past(ctl) == ctl && $past(ctl, 2) == ctl
        |-> ENCODED_OUTPUT_PIN == ctl[POS_IDLE_LVL])
        else $error("stopped line not at idle level");

    cover property (TRANSMIT_START_INTERRUPT);
    cover property (RD && ADDR == ADDR_STATUS ##1 RDATA[POS_BUSY]);
    cover property (WR && ADDR == ADDR_CONTROL && WDATA[POS_ENABLE]);
endmodule

// ---- rtl/mcg_half_tick.sv ----
module mcg_half_tick
    import mcg_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic       run,
    input  wire logic [2:0] base_sel,
    input  wire logic [4:0] baud_div,
    // half-bit tick
    output logic            tick
);

    logic [4:0] pre_cnt;
    logic [4:0] next_pre_cnt;
    logic [4:0] div_cnt;
    logic [4:0] next_div_cnt;
    logic       next_tick;
    logic       base_en;
    logic [4:0] k_val;
    logic [4:0] pre_mask;

    // ----------------------------------------
    // prescaler and 5-bit counter
    // ----------------------------------------
    // base clock divide
    // prohibited codes fall back to the slowest legal ratio
    always_comb begin
        pre_mask = 5'h00;
        case ((base_sel > BASE_SEL_MAX) ? BASE_SEL_MAX : base_sel)
            3'h0:    pre_mask = 5'h00;
            3'h1:    pre_mask = 5'h01;
            3'h2:    pre_mask = 5'h03;
            3'h3:    pre_mask = 5'h07;
            3'h4:    pre_mask = 5'h0f;
            default: pre_mask = 5'h1f;
        endcase
        base_en      = ((pre_cnt & pre_mask) == pre_mask);
        next_pre_cnt = run ? 5'(pre_cnt + 5'h01) : 5'h00;
        k_val        = (baud_div < BAUD_DIV_MIN) ? BAUD_DIV_MIN : baud_div;
        next_div_cnt = div_cnt;
        next_tick    = 1'b0;
        if (!run) begin
            next_div_cnt = 5'h00;
        end else if (base_en) begin
            if (div_cnt == 5'(k_val - 5'h01)) begin
                next_div_cnt = 5'h00;
                next_tick    = 1'b1;
            end else begin
                next_div_cnt = 5'(div_cnt + 5'h01);
            end
        end
    end

    // registers only
    always_ff @(posedge clk) begin
        if (rst) begin
            pre_cnt <= 5'h00;
            div_cnt <= 5'h00;
            tick    <= 1'b0;
        end else begin
            pre_cnt <= next_pre_cnt;
            div_cnt <= next_div_cnt;
            tick    <= next_tick;
        end
    end

endmodule

// ---- rtl/mcg_pkg.sv ----
package mcg_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [15:0] ADDR_STATUS    = 16'hff47;
    localparam logic [15:0] ADDR_BIT_COUNT = 16'hff4b;
    localparam logic [15:0] ADDR_CONTROL   = 16'hff4c;
    localparam logic [15:0] ADDR_BASE_CLK  = 16'hff4d;
    localparam logic [15:0] ADDR_BAUD_DIV  = 16'hff4e;
    localparam logic [15:0] ADDR_TX_BUFFER = 16'hff4a;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int POS_ENABLE    = 7;
    localparam int POS_BIT_ORDER = 4;
    localparam int POS_LINE_CODE = 1;
    localparam int POS_IDLE_LVL  = 0;
    localparam int POS_BUSY      = 7;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_CONTROL   = 8'h10;
    localparam logic [7:0] RST_BASE_CLK  = 8'h00;
    localparam logic [7:0] RST_BAUD_DIV  = 8'h1f;
    localparam logic [7:0] RST_BIT_COUNT = 8'h07;
    localparam logic [7:0] RST_TX_BUFFER = 8'hff;
    localparam logic [7:0] RST_STATUS    = 8'h00;

    // ----------------------------------------
    // divider constants and register write masks
    // ----------------------------------------
    localparam logic [4:0] BAUD_DIV_MIN  = 5'h04;
    localparam logic [2:0] BASE_SEL_MAX  = 3'h5;
    localparam logic [7:0] MASK_CONTROL  = 8'h93;
    localparam logic [7:0] MASK_BASE_CLK = 8'h07;
    localparam logic [7:0] MASK_BAUD_DIV = 8'h1f;
    localparam logic [7:0] MASK_BIT_CNT  = 8'h07;

    // transmitter states, gray along idle -> first half -> second half
    typedef enum logic [1:0] {
        MCG_IDLE   = 2'b00,
        MCG_HALF_A = 2'b01,
        MCG_HALF_B = 2'b11
    } mcg_state_t;

endpackage

// ---- rtl/mcg_tx.sv ----
module mcg_tx
    import mcg_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // register port
    input  wire logic [15:0] ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    // line
    output logic             ENCODED_OUTPUT_PIN,
    output logic             TRANSMIT_START_INTERRUPT
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] control;
    logic [7:0] next_control;
    logic [7:0] base_clk;
    logic [7:0] next_base_clk;
    logic [7:0] baud_div;
    logic [7:0] next_baud_div;
    logic [7:0] bit_count;
    logic [7:0] next_bit_count;
    logic [7:0] tx_buffer;
    logic [7:0] next_tx_buffer;
    logic       pending;
    logic       next_pending;
    logic       busy;
    logic       next_busy;
    // per-word copies: the shifter, the bits still to go and the bit order
    // are frozen when a word loads
    logic [7:0] shifter;
    logic [7:0] next_shifter;
    logic [2:0] bits_left;
    logic [2:0] next_bits_left;
    logic       order_lsb;
    logic       next_order_lsb;
    mcg_state_t state;
    mcg_state_t next_state;
    logic       pin;
    logic       next_pin;
    logic       start_evt;
    logic       next_start_evt;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic       tick;
    logic       enable;
    logic       cur_bit;
    logic       load_word;

    // every part of the transmitter stops with the enable bit, so a
    // disable in mid word leaves no half-sent state behind
    assign enable = control[POS_ENABLE];

    // level driven in the first half of a bit; plain levels pass through,
    // Manchester inverts so the mid-bit edge always runs towards the data
    // value and a receiver can recover the bit from the edge direction
    function automatic logic first_half(input logic nrz,
                                        input logic data_bit);
        logic lvl;
        lvl = nrz ? data_bit : ~data_bit;
        return lvl;
    endfunction

    // aligns a word so the next bit to send is always at bit 7 or bit 0;
    // a short MSB-first word is pushed up so its top bit sits at bit 7
    function automatic logic [7:0] align_word(input logic [7:0] data,
                                              input logic [2:0] cnt,
                                              input logic       lsb);
        logic [7:0] res;
        res = data;
        if (!lsb) begin
            res = 8'(data << (3'h7 - cnt));
        end
        return res;
    endfunction

    // ----------------------------------------
    // baud tick generator
    // ----------------------------------------
    // the divider only runs while enabled, so the first tick after an
    // enable comes one full half-bit period later; a start waits for it
    // two ticks per bit
    mcg_half_tick mcg_half_tick_inst (
        .clk      (CLK),
        .rst      (RST),
        .run      (enable),
        .base_sel (base_clk[2:0]),
        .baud_div (baud_div[4:0]),
        .tick     (tick)
    );

    // ----------------------------------------
    // register file
    // ----------------------------------------
    // software writes and reads; writes to status fall through unmapped
    // read data is registered and stands for one cycle only; it returns
    // zero outside a read so several slaves can be ored onto one bus
    always_comb begin
        next_control   = control;
        next_base_clk  = base_clk;
        next_baud_div  = baud_div;
        next_bit_count = bit_count;
        next_tx_buffer = tx_buffer;
        next_rdata     = 8'h00;
        if (WR) begin
            case (ADDR)
                ADDR_CONTROL:   next_control   = WDATA & MASK_CONTROL;
                ADDR_BASE_CLK:  next_base_clk  = WDATA & MASK_BASE_CLK;
                ADDR_BAUD_DIV:  next_baud_div  = WDATA & MASK_BAUD_DIV;
                ADDR_BIT_COUNT: next_bit_count = WDATA & MASK_BIT_CNT;
                ADDR_TX_BUFFER: next_tx_buffer = WDATA;
                // unmapped addresses and status land here and change nothing
                // status write ignored
                default:        next_control   = control;
            endcase
        end
        // reads have no side effect on any register
        if (RD) begin
            case (ADDR)
                ADDR_STATUS:    next_rdata = {busy, 7'h00};
                ADDR_CONTROL:   next_rdata = control;
                ADDR_BASE_CLK:  next_rdata = base_clk;
                ADDR_BAUD_DIV:  next_rdata = baud_div;
                ADDR_BIT_COUNT: next_rdata = bit_count;
                ADDR_TX_BUFFER: next_rdata = tx_buffer;
                default:        next_rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // transmitter sequencing
    // ----------------------------------------
    // bit on the line: the shifter keeps the next bit at its outgoing end
    assign cur_bit = order_lsb ? shifter[0] : shifter[7];

    // one pass per half-bit tick: first half, second half, then either the
    // next bit, the queued word or back to idle; order and length are taken
    // at the start of a word so a late write of order or length cannot tear it
    always_comb begin
        next_state     = state;
        next_shifter   = shifter;
        next_bits_left = bits_left;
        next_order_lsb = order_lsb;
        next_pending   = pending;
        next_busy      = busy;
        next_pin       = pin;
        next_start_evt = 1'b0;
        load_word      = 1'b0;
        case (state)
            MCG_IDLE: begin
                next_pin = control[POS_IDLE_LVL];
                // a start only leaves on a tick so every half bit has full length
                if (pending && tick) begin
                    load_word = 1'b1;
                end
            end
            MCG_HALF_A: begin
                if (tick) begin
                    next_state = MCG_HALF_B;
                    // mid-bit transition
                    // second half carries the data level in both codes
                    next_pin   = cur_bit;
                end
            end
            MCG_HALF_B: begin
                if (tick) begin
                    if (bits_left != 3'h0) begin
                        next_bits_left = 3'(bits_left - 3'h1);
                        next_shifter   = order_lsb ? (shifter >> 1) : 8'(shifter << 1);
                        next_state     = MCG_HALF_A;
                        // the next bit sits one place in from the outgoing end
                        next_pin       = first_half(control[POS_LINE_CODE],
                                                    order_lsb ? shifter[1] : shifter[6]);
                    end else if (pending) begin
                        load_word = 1'b1;
                    end else begin
                        next_state = MCG_IDLE;
                        next_pin   = control[POS_IDLE_LVL];
                        next_busy  = 1'b0;
                    end
                end
            end
            default: begin
                next_state = MCG_IDLE;
            end
        endcase
        if (load_word) begin
            next_pending   = 1'b0;
            next_busy      = 1'b1;
            next_order_lsb = control[POS_BIT_ORDER];
            next_bits_left = bit_count[2:0];
            next_shifter   = align_word(tx_buffer, bit_count[2:0], control[POS_BIT_ORDER]);
            next_state     = MCG_HALF_A;
            next_start_evt = 1'b1;
            next_pin       = first_half(control[POS_LINE_CODE],
                                        control[POS_BIT_ORDER] ? tx_buffer[0]
                                                               : tx_buffer[bit_count[2:0]]);
        end
        // a buffer write in the very cycle that a word is loaded or the last
        // bit ends must not be lost, so the set comes after both clears
        // write starts transfer
        if (WR && ADDR == ADDR_TX_BUFFER && enable) begin
            next_pending = 1'b1;
            next_busy    = 1'b1;
        end
        // a late tick may still meet the disable; no word and no start
        // pulse may leave the block once enable reads zero
        // enable gates all
        if (!enable) begin
            next_state     = MCG_IDLE;
            next_pending   = 1'b0;
            next_busy      = 1'b0;
            next_pin       = control[POS_IDLE_LVL];
            next_start_evt = 1'b0;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // reset is synchronous; the line starts low for one cycle and then
    // follows the idle level of the reset control value
    always_ff @(posedge CLK) begin
        if (RST) begin
            control   <= RST_CONTROL;
            base_clk  <= RST_BASE_CLK;
            baud_div  <= RST_BAUD_DIV;
            bit_count <= RST_BIT_COUNT;
            tx_buffer <= RST_TX_BUFFER;
            rdata     <= RST_STATUS;
            state     <= MCG_IDLE;
            shifter   <= 8'h00;
            bits_left <= 3'h0;
            order_lsb <= 1'b0;
            pending   <= 1'b0;
            busy      <= 1'b0;
            pin       <= 1'b0;
            start_evt <= 1'b0;
        end else begin
            control   <= next_control;
            base_clk  <= next_base_clk;
            baud_div  <= next_baud_div;
            bit_count <= next_bit_count;
            tx_buffer <= next_tx_buffer;
            rdata     <= next_rdata;
            state     <= next_state;
            shifter   <= next_shifter;
            bits_left <= next_bits_left;
            order_lsb <= next_order_lsb;
            pending   <= next_pending;
            busy      <= next_busy;
            pin       <= next_pin;
            start_evt <= next_start_evt;
        end
    end

    // outputs straight from flip-flops
    assign RDATA                    = rdata;
    assign ENCODED_OUTPUT_PIN       = pin;
    assign TRANSMIT_START_INTERRUPT = start_evt;

endmodule
